// [hw/sloa_consts.vh]
`ifndef SLOA_CONSTS_VH
`define SLOA_CONSTS_VH

// ==========================================================
// Request operation codes
`define SLOA_OP_NOP        4'h0
`define SLOA_OP_BYTE_LD    4'h1
`define SLOA_OP_SIGN_EXT   4'h2
`define SLOA_OP_ZERO_EXT   4'h3
`define SLOA_OP_NEAR_DIR   4'h4
`define SLOA_OP_MOVE_DIR   4'h5
`define SLOA_OP_PUSH       4'h6
`define SLOA_OP_POP        4'h7
`define SLOA_OP_CALL_PUSH  4'h8
`define SLOA_OP_EXC_PUSH   4'h9
`define SLOA_OP_WR_LIMIT   4'hA
`define SLOA_OP_WR_SP      4'hB
`define SLOA_OP_MOVE_EA    4'hC
`define SLOA_OP_DSP_FETCH  4'hD
`define SLOA_OP_BRANCH     4'hE
`define SLOA_OP_INT_DIS    4'hF

// ==========================================================
// Move and accumulator addressing modes
`define SLOA_AM_REG_DIR    3'h0
`define SLOA_AM_IND        3'h1
`define SLOA_AM_IND_POST   3'h2
`define SLOA_AM_IND_PRE    3'h3
`define SLOA_AM_INDEXED    3'h4
`define SLOA_AM_LIT_OFS    3'h5
`define SLOA_AM_LIT8       3'h6
`define SLOA_AM_LIT16      3'h7

// ==========================================================
// Dual-operand DSP addressing modes
`define SLOA_DM_IND        3'h0
`define SLOA_DM_POST2      3'h1
`define SLOA_DM_POST4      3'h2
`define SLOA_DM_POST6      3'h3
`define SLOA_DM_INDEXED    3'h4

// ==========================================================
// Address map and reset values
`define SLOA_NEAR_W        13
`define SLOA_SP_FLOOR      16'h0800
`define SLOA_SP_RESET      16'h0800
`define SLOA_WORD_STEP     16'h0002
`define SLOA_INTDIS_W      14

`endif

// [hw/sloa_ext_unit.v]
`timescale 1ns/1ps
`include "sloa_consts.vh"

// ==========================================================
// Byte load and extension datapath
module sloa_ext_unit
(
   // Operation
   input  wire [3:0]  op,
   // Operands
   input  wire [15:0] reg_val,
   input  wire [15:0] load_val,
   // Result
   output reg  [15:0] result
);

   always @*
   begin
      case (op)
         `SLOA_OP_BYTE_LD:  result = {reg_val[15:8], load_val[7:0]};
         `SLOA_OP_SIGN_EXT: result = {{8{reg_val[7]}}, reg_val[7:0]};
         `SLOA_OP_ZERO_EXT: result = {8'h00, reg_val[7:0]};
         default:           result = reg_val;
      endcase
   end

endmodule // sloa_ext_unit

// [hw/sloa_dsp_agu.v]
`timescale 1ns/1ps
`include "sloa_consts.vh"

// ==========================================================
// One prefetch address generator (X or Y side)
module sloa_dsp_agu
(
   // Pointer choice and mode
   input  wire        sel_second,
   input  wire [2:0]  mode,
   // Pointer values
   input  wire [15:0] ptr_first,
   input  wire [15:0] ptr_second,
   input  wire [15:0] offset_val,
   // Results
   output reg  [15:0] ea,
   output reg  [15:0] ptr_upd,
   output reg         bad_mode
);

   reg [15:0] ptr;

   always @*
   begin
      ptr      = sel_second ? ptr_second : ptr_first;
      ea       = ptr;
      ptr_upd  = ptr;
      bad_mode = 1'b0;
      case (mode)
         `SLOA_DM_IND:   ptr_upd = ptr;
         `SLOA_DM_POST2: ptr_upd = ptr + 16'h0002;
         `SLOA_DM_POST4: ptr_upd = ptr + 16'h0004;
         `SLOA_DM_POST6: ptr_upd = ptr + 16'h0006;
         `SLOA_DM_INDEXED:
         begin
            ea       = ptr + offset_val;
            bad_mode = ~sel_second;
         end
         default:        bad_mode = 1'b1;
      endcase
   end

endmodule // sloa_dsp_agu

// [hw/sloa_top.v]
`timescale 1ns/1ps
`include "sloa_consts.vh"

module sloa_top
(
   // Clock and reset
   input  wire        core_clk,
   input  wire        nrst,
   // Request from the decoder
   input  wire        req_valid,
   input  wire [3:0]  req_op,
   input  wire        req_byte,
   input  wire [15:0] req_wdata,
   input  wire [15:0] req_reg_val,
   input  wire [15:0] req_lit,
   input  wire [22:0] req_pc,
   input  wire [7:0]  req_status_low,
   // Move operand addressing
   input  wire [2:0]  req_src_mode,
   input  wire [2:0]  req_dst_mode,
   input  wire [15:0] req_src_ptr,
   input  wire [15:0] req_dst_ptr,
   input  wire        req_src_is_sp,
   input  wire        req_dst_is_sp,
   input  wire [15:0] req_offset_val,
   // Dual-operand prefetch
   input  wire        req_x_sel,
   input  wire        req_y_sel,
   input  wire [2:0]  req_x_mode,
   input  wire [2:0]  req_y_mode,
   input  wire [15:0] x_prefetch_ptr_a,
   input  wire [15:0] x_prefetch_ptr_b,
   input  wire [15:0] y_prefetch_ptr_c,
   input  wire [15:0] y_prefetch_ptr_d,
   // Answer
   output reg         busy_r,
   output reg         rsp_valid_r,
   output reg  [15:0] rsp_result_r,
   output reg  [15:0] rsp_src_ea_r,
   output reg  [15:0] rsp_dst_ea_r,
   output reg         illegal_r,
   // Data memory
   output reg         mem_wr_r,
   output reg         mem_rd_r,
   output reg  [15:0] mem_addr_r,
   output reg  [15:0] mem_wdata_r,
   // Prefetch generators
   output reg         x_rd_r,
   output reg  [15:0] x_ea_r,
   output reg  [15:0] x_ptr_upd_r,
   output reg         y_rd_r,
   output reg  [15:0] y_ea_r,
   output reg  [15:0] y_ptr_upd_r,
   // Stack state
   output reg  [15:0] stack_pointer_reg,
   output reg  [15:0] stack_limit_reg,
   output reg         stack_err_trap_r
);

   localparam ST_IDLE    = 1'b0;
   localparam ST_PUSH_HI = 1'b1;

   reg         state_r, state_nxt, limit_we, rsp_valid_nxt, illegal_nxt;
   reg         mem_wr_nxt, mem_rd_nxt, x_rd_nxt, y_rd_nxt, trap_nxt;
   reg  [15:0] hi_word_r, hi_word_nxt, sp_nxt, rsp_result_nxt, src_ea_nxt, dst_ea_nxt;
   reg  [15:0] mem_addr_nxt, mem_wdata_nxt, pop_ea;

   wire [15:0] ext_result, x_ea, x_upd, y_ea, y_upd;
   wire        x_bad, y_bad, take;

   assign take = req_valid & (state_r == ST_IDLE);

   // ==========================================================
   // Datapath helpers
   sloa_ext_unit u_ext
   (
      .op       (req_op),
      .reg_val  (req_reg_val),
      .load_val (req_wdata),
      .result   (ext_result)
   );

   // A/B feed the X read generator, C/D the Y generator
   sloa_dsp_agu u_x_read_addr_gen
   (
      .sel_second (req_x_sel),
      .mode       (req_x_mode),
      .ptr_first  (x_prefetch_ptr_a),
      .ptr_second (x_prefetch_ptr_b),
      .offset_val (req_offset_val),
      .ea         (x_ea),
      .ptr_upd    (x_upd),
      .bad_mode   (x_bad)
   );

   sloa_dsp_agu u_y_addr_gen
   (
      .sel_second (req_y_sel),
      .mode       (req_y_mode),
      .ptr_first  (y_prefetch_ptr_c),
      .ptr_second (y_prefetch_ptr_d),
      .offset_val (req_offset_val),
      .ea         (y_ea),
      .ptr_upd    (y_upd),
      .bad_mode   (y_bad)
   );

   // ==========================================================
   // Address checks and move addressing
   function stack_fault;
      input [15:0] ea;
      input [15:0] lim;
      begin
         stack_fault = (ea > lim) || (ea < `SLOA_SP_FLOOR);
      end
   endfunction

   // Both operands take the same offset register value
   function [15:0] move_ea;
      input [2:0]  mode;
      input [15:0] ptr;
      input [15:0] ofs;
      input [15:0] lit;
      input        byte_sz;
      begin
         case (mode)
            `SLOA_AM_IND_PRE: move_ea = ptr + (byte_sz ? 16'h0001 : `SLOA_WORD_STEP);
            `SLOA_AM_INDEXED: move_ea = ptr + ofs;
            `SLOA_AM_LIT_OFS: move_ea = ptr + lit;
            default:          move_ea = ptr;
         endcase
      end
   endfunction

   // ==========================================================
   // Request decode
   always @*
   begin
      state_nxt      = state_r;
      hi_word_nxt    = hi_word_r;
      sp_nxt         = stack_pointer_reg;
      limit_we       = 1'b0;
      rsp_valid_nxt  = 1'b0;
      rsp_result_nxt = rsp_result_r;
      src_ea_nxt     = rsp_src_ea_r;
      dst_ea_nxt     = rsp_dst_ea_r;
      illegal_nxt    = 1'b0;
      mem_wr_nxt     = 1'b0;
      mem_rd_nxt     = 1'b0;
      mem_addr_nxt   = mem_addr_r;
      mem_wdata_nxt  = mem_wdata_r;
      x_rd_nxt       = 1'b0;
      y_rd_nxt       = 1'b0;
      trap_nxt       = 1'b0;
      pop_ea         = stack_pointer_reg - `SLOA_WORD_STEP;
      case (state_r)
         ST_PUSH_HI:
         begin
            rsp_valid_nxt = 1'b1;
            state_nxt     = ST_IDLE;
            mem_addr_nxt  = stack_pointer_reg;
            if (stack_fault(stack_pointer_reg, stack_limit_reg))
               trap_nxt = 1'b1;
            else
            begin
               mem_wr_nxt    = 1'b1;
               mem_wdata_nxt = hi_word_r;
               sp_nxt        = stack_pointer_reg + `SLOA_WORD_STEP;
            end
         end
         default:
         begin
            if (take)
            begin
               rsp_valid_nxt = 1'b1;
               // Word-only operations refuse the byte form
               if (req_byte && (req_op != `SLOA_OP_BYTE_LD) && (req_op != `SLOA_OP_MOVE_EA)
                   && (req_op != `SLOA_OP_NEAR_DIR) && (req_op != `SLOA_OP_MOVE_DIR))
                  illegal_nxt = 1'b1;
               else
               begin
                  case (req_op)
                     `SLOA_OP_BYTE_LD, `SLOA_OP_SIGN_EXT, `SLOA_OP_ZERO_EXT: rsp_result_nxt = ext_result;
                     `SLOA_OP_NEAR_DIR: src_ea_nxt = {3'b000, req_lit[`SLOA_NEAR_W-1:0]};
                     `SLOA_OP_MOVE_DIR: src_ea_nxt = req_lit;
                     `SLOA_OP_PUSH, `SLOA_OP_CALL_PUSH, `SLOA_OP_EXC_PUSH:
                     begin
                        mem_addr_nxt = stack_pointer_reg;
                        if (stack_fault(stack_pointer_reg, stack_limit_reg))
                           trap_nxt = 1'b1;
                        else
                        begin
                           mem_wr_nxt = 1'b1;
                           sp_nxt     = stack_pointer_reg + `SLOA_WORD_STEP;
                           if (req_op == `SLOA_OP_PUSH)
                              mem_wdata_nxt = req_wdata;
                           else
                           begin
                              mem_wdata_nxt = req_pc[15:0];
                              rsp_valid_nxt = 1'b0;
                              state_nxt     = ST_PUSH_HI;
                              if (req_op == `SLOA_OP_CALL_PUSH)
                                 hi_word_nxt = {8'h00, 1'b0, req_pc[22:16]};
                              else
                                 hi_word_nxt = {req_status_low, 1'b0, req_pc[22:16]};
                           end
                        end
                     end
                     `SLOA_OP_POP:
                     begin
                        mem_addr_nxt = pop_ea;
                        if (stack_fault(pop_ea, stack_limit_reg))
                           trap_nxt = 1'b1;
                        else
                        begin
                           mem_rd_nxt = 1'b1;
                           sp_nxt     = pop_ea;
                        end
                     end
                     `SLOA_OP_WR_LIMIT: limit_we = 1'b1;
                     `SLOA_OP_WR_SP:    sp_nxt = {req_wdata[15:1], 1'b0};
                     `SLOA_OP_MOVE_EA:
                     begin
                        src_ea_nxt     = move_ea(req_src_mode, req_src_ptr, req_offset_val, req_lit, req_byte);
                        dst_ea_nxt     = move_ea(req_dst_mode, req_dst_ptr, req_offset_val, req_lit, req_byte);
                        rsp_result_nxt = (req_src_mode == `SLOA_AM_LIT8)  ? {8'h00, req_lit[7:0]} :
                                         (req_src_mode == `SLOA_AM_LIT16) ? req_lit : req_src_ptr;
                        if ((req_src_is_sp && stack_fault(src_ea_nxt, stack_limit_reg)) ||
                            (req_dst_is_sp && stack_fault(dst_ea_nxt, stack_limit_reg)))
                           trap_nxt = 1'b1;
                     end
                     `SLOA_OP_DSP_FETCH:
                     begin
                        illegal_nxt = x_bad | y_bad;
                        x_rd_nxt    = ~(x_bad | y_bad);
                        y_rd_nxt    = ~(x_bad | y_bad);
                     end
                     `SLOA_OP_BRANCH:   rsp_result_nxt = req_lit;
                     `SLOA_OP_INT_DIS:  rsp_result_nxt = {2'b00, req_lit[`SLOA_INTDIS_W-1:0]};
                     default:           rsp_result_nxt = rsp_result_r;
                  endcase
               end
            end
         end
      endcase
   end

   // ==========================================================
   // Stack limit holds no reset value
   always @(posedge core_clk)
   begin
      if (limit_we)
         stack_limit_reg <= {req_wdata[15:1], 1'b0};
   end

   // ==========================================================
   // State and output registers
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r           <= ST_IDLE;
         hi_word_r         <= 16'h0000;
         busy_r            <= 1'b0;
         rsp_valid_r       <= 1'b0;
         rsp_result_r      <= 16'h0000;
         rsp_src_ea_r      <= 16'h0000;
         rsp_dst_ea_r      <= 16'h0000;
         illegal_r         <= 1'b0;
         mem_wr_r          <= 1'b0;
         mem_rd_r          <= 1'b0;
         mem_addr_r        <= 16'h0000;
         mem_wdata_r       <= 16'h0000;
         x_rd_r            <= 1'b0;
         x_ea_r            <= 16'h0000;
         x_ptr_upd_r       <= 16'h0000;
         y_rd_r            <= 1'b0;
         y_ea_r            <= 16'h0000;
         y_ptr_upd_r       <= 16'h0000;
         stack_pointer_reg <= `SLOA_SP_RESET;
         stack_err_trap_r  <= 1'b0;
      end
      else
      begin
         state_r           <= state_nxt;
         hi_word_r         <= hi_word_nxt;
         busy_r            <= (state_nxt == ST_PUSH_HI);
         rsp_valid_r       <= rsp_valid_nxt;
         rsp_result_r      <= rsp_result_nxt;
         rsp_src_ea_r      <= src_ea_nxt;
         rsp_dst_ea_r      <= dst_ea_nxt;
         illegal_r         <= illegal_nxt;
         mem_wr_r          <= mem_wr_nxt;
         mem_rd_r          <= mem_rd_nxt;
         mem_addr_r        <= mem_addr_nxt;
         mem_wdata_r       <= mem_wdata_nxt;
         x_rd_r            <= x_rd_nxt;
         y_rd_r            <= y_rd_nxt;
         if (x_rd_nxt)
         begin
            x_ea_r      <= x_ea;
            x_ptr_upd_r <= x_upd;
            y_ea_r      <= y_ea;
            y_ptr_upd_r <= y_upd;
         end
         stack_pointer_reg <= sp_nxt;
         stack_err_trap_r  <= trap_nxt;
      end
   end

endmodule // sloa_top

// [tb/sloa_top_properties.sv]
`timescale 1ns/1ps
`include "sloa_consts.vh"

// ==========================================================
// Port checker for the addressing and stack block
module sloa_top_chk
(
   // Clock and reset
   input wire        core_clk,
   input wire        nrst,
   // Request
   input wire        req_valid,
   input wire [3:0]  req_op,
   input wire        req_byte,
   input wire [15:0] req_wdata,
   input wire [15:0] req_reg_val,
   input wire [22:0] req_pc,
   input wire [7:0]  req_status_low,
   input wire        req_x_sel,
   input wire [2:0]  req_x_mode,
   input wire [2:0]  req_y_mode,
   input wire [15:0] x_prefetch_ptr_a,
   input wire [15:0] x_prefetch_ptr_b,
   // Answer
   input wire        busy_r,
   input wire        rsp_valid_r,
   input wire [15:0] rsp_result_r,
   input wire        illegal_r,
   input wire        mem_wr_r,
   input wire [15:0] mem_addr_r,
   input wire [15:0] mem_wdata_r,
   input wire        x_rd_r,
   input wire [15:0] x_ea_r,
   input wire [15:0] x_ptr_upd_r,
   input wire        y_rd_r,
   input wire [15:0] stack_pointer_reg,
   input wire [15:0] stack_limit_reg,
   input wire        stack_err_trap_r
);
   wire take     = req_valid && !busy_r;
   wire word_go  = take && !req_byte;
   wire push_go  = word_go && req_op == `SLOA_OP_PUSH;
   wire dsp_go   = word_go && req_op == `SLOA_OP_DSP_FETCH;
   wire sp_inlim = stack_pointer_reg >= 16'h0800 && stack_pointer_reg <= stack_limit_reg;
   wire sp_out   = stack_pointer_reg < 16'h0800 || stack_pointer_reg > stack_limit_reg;
   wire [15:0] x_ptr_pick = req_x_sel ? x_prefetch_ptr_b : x_prefetch_ptr_a;

   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // ==========================================================
   // Counter pushes: low word first, then the upper word
   sequence s_frame(logic [7:0] top);
      busy_r && mem_wr_r && mem_wdata_r == $past(req_pc[15:0])
      ##1 (stack_err_trap_r || mem_wr_r && mem_wdata_r == {top, 1'b0, $past(req_pc[22:16], 2)});
   endsequence

   property p_sign_ext;
      word_go && req_op == `SLOA_OP_SIGN_EXT |=>
         rsp_valid_r && rsp_result_r == {{8{$past(req_reg_val[7])}}, $past(req_reg_val[7:0])};
   endproperty
   a_sign_ext : assert property (p_sign_ext)
      else $error("sign extend result wrong");

   property p_push;
      push_go |=> stack_err_trap_r ? (!mem_wr_r && $stable(stack_pointer_reg)) :
         (mem_wr_r && mem_addr_r == $past(stack_pointer_reg)
          && stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002);
   endproperty
   a_push : assert property (p_push)
      else $error("push step wrong");

   property p_limit_ok;
      push_go && sp_inlim |=> !stack_err_trap_r;
   endproperty
   a_limit_ok : assert property (p_limit_ok)
      else $error("push inside limit trapped");

   property p_fault;
      push_go && sp_out |=> stack_err_trap_r && !mem_wr_r;
   endproperty
   a_fault : assert property (p_fault)
      else $error("stack fault not trapped");

   property p_lim_wr;
      word_go && req_op == `SLOA_OP_WR_LIMIT |=> stack_limit_reg == {$past(req_wdata[15:1]), 1'b0};
   endproperty
   a_lim_wr : assert property (p_lim_wr)
      else $error("limit write wrong");

   property p_call_frame;
      word_go && req_op == `SLOA_OP_CALL_PUSH ##1 !stack_err_trap_r |-> s_frame(8'h00);
   endproperty
   a_call_frame : assert property (p_call_frame)
      else $error("call frame wrong");

   property p_exc_frame;
      word_go && req_op == `SLOA_OP_EXC_PUSH ##1 !stack_err_trap_r |-> s_frame($past(req_status_low, 2));
   endproperty
   a_exc_frame : assert property (p_exc_frame)
      else $error("exception frame wrong");

   property p_dsp_x;
      dsp_go && req_x_mode < 3'h4 && req_y_mode < 3'h4 |=> x_rd_r && y_rd_r
         && x_ea_r == $past(x_ptr_pick)
         && x_ptr_upd_r == x_ea_r + {12'h000, $past(req_x_mode), 1'b0};
   endproperty
   a_dsp_x : assert property (p_dsp_x)
      else $error("x prefetch address wrong");

   property p_dsp_bad;
      dsp_go && (req_x_mode > 3'h4 || req_x_mode == 3'h4 && !req_x_sel) |=> illegal_r && !x_rd_r && !y_rd_r;
   endproperty
   a_dsp_bad : assert property (p_dsp_bad)
      else $error("bad prefetch mode accepted");

   property p_word_only;
      take && req_byte && (req_op == `SLOA_OP_SIGN_EXT || req_op == `SLOA_OP_DSP_FETCH
         || req_op == `SLOA_OP_PUSH) |=> rsp_valid_r && illegal_r && !mem_wr_r && !x_rd_r;
   endproperty
   a_word_only : assert property (p_word_only)
      else $error("byte form accepted");
endmodule // sloa_top_chk

bind sloa_top sloa_top_chk u_chk (.*);

// [tb/sloa_pipe_model.sv]
`timescale 1ns/1ps

// ==========================================================
// Data memory behind the pipeline, word wide
module sloa_pipe_model
(
   // Clock
   input wire        core_clk,
   // Write port
   input wire        mem_wr_r,
   input wire [15:0] mem_addr_r,
   input wire [15:0] mem_wdata_r
);
   logic [15:0] mem [0:32767];
   integer      i;

   initial
   begin
      for (i = 0; i < 32768; i = i + 1)
         mem[i] = 16'h0000;
   end

   // Stack slots are word aligned, so bit 0 is dropped
   always @(posedge core_clk)
   begin
      if (mem_wr_r)
         mem[mem_addr_r[15:1]] <= mem_wdata_r;
   end
endmodule // sloa_pipe_model

// [tb/sloa_top_tb_top.sv]
`timescale 1ns/1ps
`include "sloa_consts.vh"

// ==========================================================
// Self-checking bench
module sloa_top_tb_top;
   logic        core_clk, nrst, req_valid, req_byte, req_src_is_sp, req_dst_is_sp, req_x_sel, req_y_sel;
   logic [3:0]  req_op;
   logic [2:0]  req_src_mode, req_dst_mode, req_x_mode, req_y_mode;
   logic [7:0]  req_status_low;
   logic [22:0] req_pc;
   logic [15:0] req_wdata, req_reg_val, req_lit, req_src_ptr, req_dst_ptr, req_offset_val;
   logic [15:0] x_prefetch_ptr_a, x_prefetch_ptr_b, y_prefetch_ptr_c, y_prefetch_ptr_d;
   logic        busy_r, rsp_valid_r, illegal_r, mem_wr_r, mem_rd_r, x_rd_r, y_rd_r, stack_err_trap_r;
   logic [15:0] rsp_result_r, rsp_src_ea_r, rsp_dst_ea_r, mem_addr_r, mem_wdata_r;
   logic [15:0] x_ea_r, x_ptr_upd_r, y_ea_r, y_ptr_upd_r, stack_pointer_reg, stack_limit_reg;
   integer      err_count, n_checks;

   sloa_top dut (.*);
   sloa_pipe_model u_mem (.core_clk(core_clk), .mem_wr_r(mem_wr_r), .mem_addr_r(mem_addr_r),
                          .mem_wdata_r(mem_wdata_r));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One request, then wait for its answer
   task issue(input logic [3:0] op, input logic byt, input logic [15:0] wd);
      integer i;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_byte <= byt;
      req_wdata <= wd;
      @(posedge core_clk);
      req_valid <= 1'b0;
      #1;
      for (i = 0; i < 4 && rsp_valid_r !== 1'b1; i = i + 1)
      begin
         @(posedge core_clk);
         #1;
      end
      chk(rsp_valid_r, 1'b1);
   endtask

   task t_ext;
      req_reg_val <= 16'h5A3C;
      issue(`SLOA_OP_BYTE_LD, 1'b1, 16'h00F1);
      chk(rsp_result_r, 16'h5AF1);
      req_reg_val <= 16'h1280;
      issue(`SLOA_OP_SIGN_EXT, 1'b0, 16'h0000);
      chk(rsp_result_r, 16'hFF80);
      req_reg_val <= 16'h127F;
      issue(`SLOA_OP_SIGN_EXT, 1'b0, 16'h0000);
      chk(rsp_result_r, 16'h007F);
      req_reg_val <= 16'hABCD;
      issue(`SLOA_OP_ZERO_EXT, 1'b0, 16'h0000);
      chk(rsp_result_r, 16'h00CD);
      issue(`SLOA_OP_SIGN_EXT, 1'b1, 16'h0000);
      chk(illegal_r, 1'b1);
      $display("t_ext done");
   endtask

   task t_dir;
      req_lit <= 16'hFFFF;
      issue(`SLOA_OP_NEAR_DIR, 1'b0, 16'h0000);
      chk(rsp_src_ea_r, 16'h1FFF);
      req_lit <= 16'hFFFE;
      issue(`SLOA_OP_MOVE_DIR, 1'b0, 16'h0000);
      chk(rsp_src_ea_r, 16'hFFFE);
      req_src_mode <= `SLOA_AM_INDEXED;
      req_dst_mode <= `SLOA_AM_IND;
      issue(`SLOA_OP_MOVE_EA, 1'b0, 16'h0000);
      chk(rsp_src_ea_r, 16'h1010);
      chk(rsp_dst_ea_r, 16'h2000);
      req_src_mode <= `SLOA_AM_IND;
      req_dst_mode <= `SLOA_AM_INDEXED;
      issue(`SLOA_OP_MOVE_EA, 1'b0, 16'h0000);
      chk(rsp_src_ea_r, 16'h1000);
      chk(rsp_dst_ea_r, 16'h2010);
      chk(rsp_result_r, 16'h1000);
      req_lit <= 16'h8004;
      issue(`SLOA_OP_BRANCH, 1'b0, 16'h0000);
      chk(rsp_result_r, 16'h8004);
      req_lit <= 16'hFFFF;
      issue(`SLOA_OP_INT_DIS, 1'b0, 16'h0000);
      chk(rsp_result_r, 16'h3FFF);
      req_src_mode <= `SLOA_AM_LIT8;
      issue(`SLOA_OP_MOVE_EA, 1'b0, 16'h0000);
      chk(rsp_result_r, 16'h00FF);
      req_src_mode <= `SLOA_AM_LIT16;
      issue(`SLOA_OP_MOVE_EA, 1'b0, 16'h0000);
      chk(rsp_result_r, 16'hFFFF);
      $display("t_dir done");
   endtask

   task t_stack;
      issue(`SLOA_OP_WR_LIMIT, 1'b0, 16'h0805);
      chk(stack_limit_reg, 16'h0804);
      issue(`SLOA_OP_WR_SP, 1'b0, 16'h0800);
      issue(`SLOA_OP_PUSH, 1'b0, 16'hA001);
      issue(`SLOA_OP_PUSH, 1'b0, 16'hA002);
      chk(u_mem.mem[15'h0400], 16'hA001);
      chk(stack_pointer_reg, 16'h0804);
      issue(`SLOA_OP_PUSH, 1'b0, 16'hA003);
      chk(stack_err_trap_r, 1'b0);
      issue(`SLOA_OP_PUSH, 1'b0, 16'hA004);
      chk(stack_err_trap_r, 1'b1);
      chk(stack_pointer_reg, 16'h0806);
      chk(mem_wr_r, 1'b0);
      issue(`SLOA_OP_POP, 1'b0, 16'h0000);
      chk(u_mem.mem[15'h0403], 16'h0000);
      chk(mem_rd_r, 1'b1);
      chk(mem_addr_r, 16'h0804);
      chk(stack_pointer_reg, 16'h0804);
      issue(`SLOA_OP_WR_SP, 1'b0, 16'h07FE);
      issue(`SLOA_OP_PUSH, 1'b0, 16'hA005);
      chk(stack_err_trap_r, 1'b1);
      $display("t_stack done");
   endtask

   task t_call;
      issue(`SLOA_OP_WR_LIMIT, 1'b0, 16'h0FFE);
      issue(`SLOA_OP_WR_SP, 1'b0, 16'h0900);
      req_pc <= 23'h5A_1234;
      issue(`SLOA_OP_CALL_PUSH, 1'b0, 16'h0000);
      @(posedge core_clk) #1;
      chk(u_mem.mem[15'h0480], 16'h1234);
      chk(u_mem.mem[15'h0481], 16'h005A);
      req_status_low <= 8'hC3;
      issue(`SLOA_OP_EXC_PUSH, 1'b0, 16'h0000);
      @(posedge core_clk) #1;
      chk(u_mem.mem[15'h0483], 16'hC35A);
      chk(stack_pointer_reg, 16'h0908);
      req_src_is_sp <= 1'b1;
      req_src_mode <= `SLOA_AM_IND;
      issue(`SLOA_OP_MOVE_EA, 1'b0, 16'h0000);
      chk(stack_err_trap_r, 1'b1);
      $display("t_call done");
   endtask

   // Each post-increment mode on both sides, then indexed and the refused forms
   task t_dsp;
      integer m;
      for (m = 0; m < 4; m = m + 1)
      begin
         req_x_sel <= m[0];
         req_y_sel <= m[0];
         req_x_mode <= m[2:0];
         req_y_mode <= m[2:0];
         issue(`SLOA_OP_DSP_FETCH, 1'b0, 16'h0000);
         chk(x_ea_r, m[0] ? 16'h0B00 : 16'h0A00);
         chk(y_ea_r, m[0] ? 16'h1D00 : 16'h1C00);
         chk(y_ptr_upd_r, (m[0] ? 16'h1D00 : 16'h1C00) + {m[14:0], 1'b0});
      end
      req_x_mode <= `SLOA_DM_INDEXED;
      req_y_mode <= `SLOA_DM_INDEXED;
      issue(`SLOA_OP_DSP_FETCH, 1'b0, 16'h0000);
      chk(x_ea_r, 16'h0B10);
      chk(y_ea_r, 16'h1D10);
      req_x_sel <= 1'b0;
      issue(`SLOA_OP_DSP_FETCH, 1'b0, 16'h0000);
      chk(illegal_r, 1'b1);
      issue(`SLOA_OP_DSP_FETCH, 1'b1, 16'h0000);
      chk(illegal_r, 1'b1);
      $display("t_dsp done");
   endtask

   task close_out;
      $display("Checks made %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      #50000;
      err_count = err_count + 1;
      close_out;
   end

   initial
   begin
      err_count = 0;
      n_checks = 0;
      {nrst, req_valid, req_byte, req_src_is_sp, req_dst_is_sp, req_x_sel, req_y_sel} = 7'h00;
      {req_op, req_src_mode, req_dst_mode, req_x_mode, req_y_mode, req_status_low, req_pc} = 47'h0;
      {req_wdata, req_reg_val, req_lit} = 48'h0;
      req_src_ptr = 16'h1000;
      req_dst_ptr = 16'h2000;
      req_offset_val = 16'h0010;
      x_prefetch_ptr_a = 16'h0A00;
      x_prefetch_ptr_b = 16'h0B00;
      y_prefetch_ptr_c = 16'h1C00;
      y_prefetch_ptr_d = 16'h1D00;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      chk(stack_pointer_reg, 16'h0800);
      chk(rsp_valid_r, 1'b0);
      t_ext;
      t_dir;
      t_stack;
      t_call;
      t_dsp;
      close_out;
   end
endmodule // sloa_top_tb_top
